// [rtl/rfc_regs.svh]
/*
  Register offsets, field positions, reset values and filter constants of
  the receive address filter control block.
  Assumes an APB slave with 32-bit data and one aligned word per register.
*/
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH
`define RFC_CTL_OFS 12'h048
`define RFC_DATA_OFS 12'h04C
`define RFC_CTL_RESET 32'h00000000
`define RFC_CTL_WMASK 32'hFFF803FF
`define RFC_CTL_CFG_HI 30
`define RFC_CTL_CFG_LO 19
`define RFC_EXT_CNT 10'h006
`define RFC_EXT_PW 10'h00A
`define RFC_EXT_PW_END 10'h010
`define RFC_EXT_MEM 10'h200
`define RFC_PAT_BASE0 8'h40
`define RFC_PAT_BASE1 8'h41
`define RFC_PAT_BASE2 8'h80
`define RFC_PAT_BASE3 8'h81
`define RFC_ARP_HI 8'h08
`define RFC_ARP_LO 8'h06
`define RFC_DA_LAST 11'h005
`define RFC_TYPE_HI_POS 11'h00C
`define RFC_TYPE_LO_POS 11'h00D
`define RFC_ULM_BIT 1
`define RFC_CRC_INIT 32'hFFFFFFFF
`define RFC_CRC_POLY 32'hEDB88320
`endif

// [rtl/rfc_pkg.sv]
/*
  Types of the receive address filter control block.
  Assumes the register constants header is included alongside.
*/
package rfc_pkg;
  // bit layout of the receive filter control register
  typedef struct packed {
    logic filter_enable;
    logic accept_all_broadcast;
    logic accept_all_multicast;
    logic accept_all_unicast;
    logic accept_perfect_match;
    logic [3:0] accept_pattern_enables;
    logic accept_arp_frames;
    logic multicast_hash_enable;
    logic unicast_hash_enable;
    logic universal_local_bit_mask;
    logic [8:0] reserved;
    logic [9:0] filter_extended_address;
  } rfc_ctl_s;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } rfc_rx_byte_s;

  typedef struct packed {
    logic valid;
    logic accept;
  } rfc_verdict_s;

  typedef enum logic [4:0] {
    RFC_SEL_NONE = 5'h01,
    RFC_SEL_PM = 5'h02,
    RFC_SEL_CNT = 5'h04,
    RFC_SEL_PW = 5'h08,
    RFC_SEL_MEM = 5'h10
  } rfc_sel_e;
endpackage

// [rtl/rfc_filter.sv]
/*
  Receive address filter: control and data port registers on APB, the
  indirectly reached filter registers and filter memory, and the per-frame
  accept decision.
  Assumes received bytes arrive on pclk from the MAC receive path, one byte
  per valid cycle, first and last marking frame edges.
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "rfc_regs.svh"
module rfc_filter
  import rfc_pkg::*;
#(
  parameter int MEM_WORDS = 256,
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rfc_rx_byte_s rx_byte,
  output rfc_verdict_s verdict,
  output logic [47:0] wake_password
);

  rfc_ctl_s ctl_r;
  logic [47:0] pm_r;
  logic [47:0] pw_r;
  logic [CNT_W-1:0] cnt_r [4];
  logic [17:0] mem_r [MEM_WORDS];
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  rfc_verdict_s verdict_r;

  // extended address decode, shared by the read mux and the write path
  function automatic rfc_sel_e ext_decode(input logic [9:0] a);
    if (a[0]) begin
      return RFC_SEL_NONE;
    end
    if (a >= `RFC_EXT_MEM) begin
      return RFC_SEL_MEM;
    end
    if (a < `RFC_EXT_CNT) begin
      return RFC_SEL_PM;
    end
    if (a < `RFC_EXT_PW) begin
      return RFC_SEL_CNT;
    end
    if (a < `RFC_EXT_PW_END) begin
      return RFC_SEL_PW;
    end
    return RFC_SEL_NONE;
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RFC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [9:0] ext_a;
  rfc_sel_e ext_sel;
  logic [1:0] pm_k;
  logic cnt_k;
  logic [1:0] pw_k;
  logic [7:0] mem_i;
  logic [17:0] rd_word;
  logic apb_acc;
  logic apb_done;
  logic hit_ctl;
  logic hit_data;

  assign ext_a = ctl_r.filter_extended_address;
  assign ext_sel = ext_decode(ext_a);
  assign pm_k = ext_a[2:1];
  assign cnt_k = ext_a[3];
  assign pw_k = ext_a[2:1] - 2'h1;
  assign mem_i = ext_a[8:1];
  assign apb_acc = psel & penable;
  assign apb_done = apb_acc & pready_r;
  assign hit_ctl = (paddr == `RFC_CTL_OFS);
  assign hit_data = (paddr == `RFC_DATA_OFS);

  always_comb begin
    rd_word = 18'h00000;
    case (ext_sel)
      RFC_SEL_PM: rd_word = {2'h0, pm_r[16*pm_k +: 16]};
      RFC_SEL_CNT: rd_word = {2'h0, cnt_r[{cnt_k, 1'b1}], cnt_r[{cnt_k, 1'b0}]};
      RFC_SEL_PW: rd_word = {2'h0, pw_r[16*pw_k +: 16]};
      RFC_SEL_MEM: rd_word = mem_r[mem_i];
      default: rd_word = 18'h00000;
    endcase
  end

  // one wait state keeps every bus output straight from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= apb_acc & ~pready_r;
      pslverr_r <= apb_acc & ~pready_r & ~(hit_ctl | hit_data);
      if (apb_acc && !pready_r && !pwrite && hit_ctl) begin
        prdata_r <= ctl_r;
      end else if (apb_acc && !pready_r && !pwrite && hit_data) begin
        prdata_r <= {14'h0000, rd_word};
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= `RFC_CTL_RESET;
    end else if (apb_done && pwrite && hit_ctl) begin
      ctl_r <= pwdata & `RFC_CTL_WMASK;
      if (ctl_r.filter_enable) begin
        ctl_r[`RFC_CTL_CFG_HI:`RFC_CTL_CFG_LO] <= ctl_r[`RFC_CTL_CFG_HI:`RFC_CTL_CFG_LO];
      end
    end
  end

  logic wr_ext;
  assign wr_ext = apb_done & pwrite & hit_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_r <= 48'h000000000000;
    end else if (wr_ext && ext_sel == RFC_SEL_PM) begin
      pm_r[16*pm_k +: 16] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_r <= 48'h000000000000;
    end else if (wr_ext && ext_sel == RFC_SEL_PW) begin
      pw_r[16*pw_k +: 16] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        cnt_r[i] <= '0;
      end
    end else if (wr_ext && ext_sel == RFC_SEL_CNT) begin
      cnt_r[{cnt_k, 1'b0}] <= pwdata[7:0];
      cnt_r[{cnt_k, 1'b1}] <= pwdata[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_r[i] <= 18'h00000;
      end
    end else if (wr_ext && ext_sel == RFC_SEL_MEM) begin
      mem_r[mem_i] <= pwdata[17:0];
    end
  end

  // frame side: pos is the index of the byte now on rx_byte
  logic [10:0] byte_cnt_r;
  logic [10:0] pos;
  logic pm_ok_r;
  logic bc_ok_r;
  logic mc_r;
  logic arp_hi_r;
  logic arp_ok_r;
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;
  logic [8:0] hash_idx_r;
  logic dec_r;
  logic [7:0] pm_byte;
  logic [7:0] pm_mask;
  logic pm_byte_hit;

  assign pos = rx_byte.first ? 11'h000 : byte_cnt_r;
  assign crc_nxt = crc_step(rx_byte.first ? `RFC_CRC_INIT : crc_r, rx_byte.data);
  // octet zero meets the first address byte
  assign pm_byte = pm_r[8*pos[2:0] +: 8];
  // u/l bit is a don't-care when masked
  assign pm_mask = (pos == 11'h000 && ctl_r.universal_local_bit_mask) ?
                   (8'hFF ^ (8'h01 << `RFC_ULM_BIT)) : 8'hFF;
  assign pm_byte_hit = ((pm_byte ^ rx_byte.data) & pm_mask) == 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_cnt_r <= 11'h000;
      dec_r <= 1'b0;
    end else begin
      dec_r <= rx_byte.valid & rx_byte.last;
      if (rx_byte.valid) begin
        byte_cnt_r <= (pos == 11'h7FF) ? pos : pos + 11'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_ok_r <= 1'b0;
      bc_ok_r <= 1'b0;
      mc_r <= 1'b0;
    end else if (rx_byte.valid && pos <= `RFC_DA_LAST) begin
      pm_ok_r <= (rx_byte.first | pm_ok_r) & pm_byte_hit;
      bc_ok_r <= (rx_byte.first | bc_ok_r) & (rx_byte.data == 8'hFF);
      if (rx_byte.first) begin
        mc_r <= rx_byte.data[0];
      end
    end
  end

  // hash index from the address crc
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_r <= `RFC_CRC_INIT;
      hash_idx_r <= 9'h000;
    end else if (rx_byte.valid && pos <= `RFC_DA_LAST) begin
      crc_r <= crc_nxt;
      if (pos == `RFC_DA_LAST) begin
        hash_idx_r <= ~crc_nxt[8:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arp_hi_r <= 1'b0;
      arp_ok_r <= 1'b0;
    end else if (rx_byte.valid) begin
      if (rx_byte.first) begin
        arp_hi_r <= 1'b0;
        arp_ok_r <= 1'b0;
      end else if (pos == `RFC_TYPE_HI_POS) begin
        arp_hi_r <= (rx_byte.data == `RFC_ARP_HI);
      end else if (pos == `RFC_TYPE_LO_POS) begin
        arp_ok_r <= arp_hi_r & (rx_byte.data == `RFC_ARP_LO);
      end
    end
  end

  logic [3:0] pat_hit;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_pat
      localparam logic [7:0] BASE = (b == 0) ? `RFC_PAT_BASE0 : (b == 1) ? `RFC_PAT_BASE1 :
                                    (b == 2) ? `RFC_PAT_BASE2 : `RFC_PAT_BASE3;
      logic [7:0] idx;
      logic [17:0] w;
      logic byte_hit;
      logic in_count;
      logic ok_r;
      // buffers interleave word by word, two bytes per word
      assign idx = BASE + {1'b0, pos[6:1], 1'b0};
      assign w = mem_r[idx];
      assign byte_hit = (pos[0] ? w[17] : w[16]) |
                        ((pos[0] ? w[15:8] : w[7:0]) == rx_byte.data);
      assign in_count = pos < {{(11 - CNT_W){1'b0}}, cnt_r[b]};
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ok_r <= 1'b0;
        end else if (rx_byte.valid) begin
          ok_r <= (rx_byte.first | ok_r) & (~in_count | byte_hit);
        end
      end
      // a zero count or a frame shorter than the count never matches
      assign pat_hit[b] = ctl_r.accept_pattern_enables[b] & ok_r & (cnt_r[b] != '0) &
                          (byte_cnt_r >= {{(11 - CNT_W){1'b0}}, cnt_r[b]});
    end
  endgenerate

  logic hash_bit;
  logic is_bc;
  logic is_mc;
  logic is_uc;
  logic pm_hit;
  logic mc_ok;
  logic uc_ok;
  logic accept_c;

  assign hash_bit = mem_r[{3'h0, hash_idx_r[8:4]}][hash_idx_r[3:0]];
  assign is_bc = bc_ok_r;
  assign is_mc = mc_r & ~bc_ok_r;
  assign is_uc = ~mc_r;
  assign pm_hit = ctl_r.accept_perfect_match & pm_ok_r;
  assign mc_ok = is_mc & (ctl_r.accept_all_multicast |
                          (ctl_r.multicast_hash_enable & hash_bit));
  assign uc_ok = is_uc & (ctl_r.accept_all_unicast | (ctl_r.unicast_hash_enable & hash_bit));
  assign accept_c = ctl_r.filter_enable &
                    ((is_bc & ctl_r.accept_all_broadcast) | mc_ok | uc_ok | pm_hit |
                     (|pat_hit) | (ctl_r.accept_arp_frames & arp_ok_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verdict_r <= '0;
    end else begin
      verdict_r.valid <= dec_r;
      verdict_r.accept <= dec_r & accept_c;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign verdict = verdict_r;
  assign wake_password = pw_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_frame_end;
    rx_byte.valid && rx_byte.last;
  endsequence
  sequence s_ctl_write;
    apb_done && pwrite && hit_ctl;
  endsequence
  sequence s_accepted;
    verdict_r.valid && verdict_r.accept;
  endsequence

  a_disabled_rejects: assert property (
    s_frame_end ##1 !ctl_r.filter_enable |=> verdict_r.valid && !verdict_r.accept)
    else $error("frame accepted while filter disabled");
  a_bcast_accept: assert property (
    s_frame_end ##1 (ctl_r.filter_enable && ctl_r.accept_all_broadcast && bc_ok_r)
    |=> s_accepted)
    else $error("broadcast frame not accepted");
  a_mcast_accept: assert property (
    s_frame_end ##1 (ctl_r.filter_enable && ctl_r.accept_all_multicast && is_mc)
    |=> s_accepted)
    else $error("multicast frame not accepted");
  a_ucast_accept: assert property (
    s_frame_end ##1 (ctl_r.filter_enable && ctl_r.accept_all_unicast && is_uc)
    |=> s_accepted)
    else $error("unicast frame not accepted");
  a_perfect_match_address_accept: assert property (
    s_frame_end ##1 (ctl_r.filter_enable && pm_hit) |=> s_accepted)
    else $error("perfect match frame not accepted");
  a_pattern_accept: assert property (
    s_frame_end ##1 (ctl_r.filter_enable && |pat_hit) |=> s_accepted)
    else $error("pattern match frame not accepted");
  a_arp_accept: assert property (
    s_frame_end ##1 (ctl_r.filter_enable && ctl_r.accept_arp_frames && arp_ok_r)
    |=> s_accepted)
    else $error("arp frame not accepted");
  a_mhash_accept: assert property (
    s_frame_end ##1 (ctl_r.filter_enable && ctl_r.multicast_hash_enable && is_mc && hash_bit)
    |=> s_accepted)
    else $error("multicast hash hit not accepted");
  a_cfg_frozen: assert property (
    s_ctl_write ##0 ctl_r.filter_enable |=> $stable(ctl_r[30:19]))
    else $error("configuration changed while enabled");
  a_pm_write: assert property (
    apb_done && pwrite && hit_data && ext_a == 10'h000 |=> pm_r[15:0] == $past(pwdata[15:0]))
    else $error("perfect match octets 1-0 not written");
  a_reset_zero: assert property (@(posedge pclk) disable iff (1'b0)
    $rose(presetn) |-> ctl_r == '0)
    else $error("control register not zero after reset");
endmodule

// [verification/rfc_filter_tb.sv]
/*
  Self-checking bench of the receive filter control block: APB master tasks,
  a frame driver and a behavioural accept model compared at every verdict.
  Assumes one clock, an APB slave that answers by pready, one verdict per frame.
*/
`timescale 1ns/1ps
`include "rfc_regs.svh"
module testbench
  import rfc_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rfc_rx_byte_s rx_byte;
  rfc_verdict_s verdict;
  logic [47:0] wake_password;
  int bad_count;
  int tests_run;
  int cyc;
  int seed;
  logic [31:0] rdat;
  logic [31:0] m_ctl;
  logic [31:0] m_cnt;
  logic [47:0] m_pm, m_pw, da_hm, da_hu, da_pt;
  logic [17:0] m_mem [256];
  logic [7:0] fr[$];
  logic [31:0] modes [13] = '{32'h7FF80000, 32'h80000000, 32'hC0000000, 32'hA0000000,
    32'h90000000, 32'h88000000, 32'h88080000, 32'h80800000, 32'h84000000, 32'h80400000,
    32'h80200000, 32'h80100000, 32'h87800000};

  rfc_filter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_byte(rx_byte), .verdict(verdict), .wake_password(wake_password));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic results();
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    chk({pready, pslverr}, {1'b1, err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic ctlw(input logic [31:0] d);
    apb(1'b1, `RFC_CTL_OFS, d, 1'b0);
    if (m_ctl[31])
      m_ctl = {d[31], m_ctl[30:19], 9'h0, d[9:0]};
    else
      m_ctl = d & 32'hFFF803FF;
  endtask

  function automatic logic [31:0] iexp(input logic [9:0] a);
    if (a[0] || (a >= 10'h010 && a < 10'h200))
      return 32'h0;
    if (a >= 10'h200)
      return {14'h0, m_mem[a[8:1]]};
    if (a < 10'h006)
      return {16'h0, m_pm[a[2:1] * 16 +: 16]};
    if (a < 10'h00A)
      return {16'h0, m_cnt[(a - 10'h6) * 8 +: 16]};
    return {16'h0, m_pw[(a - 10'hA) * 8 +: 16]};
  endfunction

  task automatic iw(input logic [9:0] a, input logic [17:0] d);
    ctlw({m_ctl[31:10], a});
    apb(1'b1, `RFC_DATA_OFS, {14'h0, d}, 1'b0);
    if (a >= 10'h200)
      m_mem[a[8:1]] = d;
    else if (a < 10'h006)
      m_pm[a[2:1] * 16 +: 16] = d[15:0];
    else if (a < 10'h00A)
      m_cnt[(a - 10'h6) * 8 +: 16] = d[15:0];
    else
      m_pw[(a - 10'hA) * 8 +: 16] = d[15:0];
  endtask

  task automatic ir(input logic [9:0] a);
    ctlw({m_ctl[31:10], a});
    apb(1'b0, `RFC_DATA_OFS, 32'h0, 1'b0);
    chk(rdat, iexp(a));
  endtask

  function automatic logic [8:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++)
      c = (c[0] ^ da[i]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    return ~c[8:0];
  endfunction

  function automatic logic model();
    logic [47:0] da;
    logic [17:0] w;
    logic bc, mc, uc, a, ok;
    logic [8:0] h;
    int n;
    for (int i = 0; i < 6; i++)
      da[8 * i +: 8] = fr[i];
    bc = &da;
    mc = da[0] & !bc;
    uc = !da[0];
    h = hidx(da);
    a = (bc & m_ctl[30]) | (mc & m_ctl[29]) | (uc & m_ctl[28]);
    if (m_ctl[27] && ((da ^ m_pm) & ~{46'h0, m_ctl[19], 1'b0}) == 48'h0)
      a = 1'b1;
    for (int b = 0; b < 4; b++) begin
      n = m_cnt[8 * b +: 8];
      ok = m_ctl[23 + b] && n != 0 && fr.size() >= n;
      for (int j = 0; j < n && ok; j++) begin
        w = m_mem[8'(((b < 2) ? 8'h40 : 8'h80) + b % 2 + 2 * (j / 2))];
        if (!w[16 + j % 2] && w[8 * (j % 2) +: 8] != fr[j])
          ok = 1'b0;
      end
      a |= ok;
    end
    a |= m_ctl[22] & (fr[12] == 8'h08) & (fr[13] == 8'h06);
    a |= m_mem[{3'h0, h[8:4]}][h[3:0]] & ((mc & m_ctl[21]) | (uc & m_ctl[20]));
    return a & m_ctl[31];
  endfunction

  task automatic mkf(input int k);
    logic [47:0] da;
    da = 48'({$random(seed), $random(seed)});
    case (k)
      0: da = '1;
      1: da[0] = 1'b1;
      2: da[0] = 1'b0;
      3: da = m_pm;
      4: da = m_pm ^ 48'h2;
      5: da = da_hm;
      6: da = da_hu;
      7: da[0] = 1'b0;
      default: da = da_pt ^ 48'hFF0000;
    endcase
    fr = {};
    for (int i = 0; i < 18; i++)
      fr.push_back(i < 6 ? da[8 * i +: 8] : 8'($random(seed)));
    if (k == 7) begin
      fr[12] = 8'h08;
      fr[13] = 8'h06;
    end
  endtask

  task automatic send();
    int n;
    logic exp;
    exp = model();
    foreach (fr[i]) begin
      rx_byte <= {1'b1, i == 0, i == fr.size() - 1, fr[i]};
      @(posedge pclk);
    end
    rx_byte <= '0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (verdict.valid !== 1'b1 && n < 8);
    chk({n, verdict.accept}, {32'd2, exp});
    @(posedge pclk);
  endtask

  task automatic hset(input logic [47:0] da);
    logic [8:0] h;
    h = hidx(da);
    iw(10'h200 + {h[8:4], 1'b0}, m_mem[{3'h0, h[8:4]}] | (18'h1 << h[3:0]));
    ir(10'h200 + {h[8:4], 1'b0});
  endtask

  initial begin
    seed = 32'hE71712B4;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_byte = '0;
    m_ctl = 32'h0;
    m_cnt = 32'h0;
    m_pm = 48'h0;
    m_pw = 48'h0;
    foreach (m_mem[i])
      m_mem[i] = 18'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `RFC_CTL_OFS, 32'h0, 1'b0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h050, 32'h0, 1'b1);
    chk(rdat, 32'h0);
    for (int a = 0; a < 16; a += 2)
      iw(10'(a), 18'($random(seed)) & 18'h0FFFF);
    iw(10'h006, 18'h02004);
    iw(10'h008, 18'h00240);
    for (int a = 0; a < 16; a += 2)
      ir(10'(a));
    chk(wake_password, m_pw);
    ir(10'h011);
    ir(10'h100);
    da_hm = 48'({$random(seed), $random(seed)}) | 48'h1;
    da_hu = 48'({$random(seed), $random(seed)}) & ~48'h1;
    da_pt = 48'({$random(seed), $random(seed)}) & ~48'h1;
    hset(da_hm);
    hset(da_hu);
    iw(10'h280, {2'b00, da_pt[15:0]});
    iw(10'h284, {2'b01, da_pt[31:16]});
    iw(10'h302, {2'b00, m_pm[15:0]});
    ir(10'h284);
    foreach (modes[m]) begin
      ctlw(32'h0);
      ctlw(modes[m]);
      apb(1'b0, `RFC_CTL_OFS, 32'h0, 1'b0);
      chk(rdat, m_ctl);
      for (int k = 0; k < 9; k++) begin
        mkf(k);
        send();
      end
    end
    ctlw(32'hC00003FF);
    apb(1'b0, `RFC_CTL_OFS, 32'h0, 1'b0);
    chk(rdat, m_ctl);
    for (int r = 0; r < 30; r++) begin
      ctlw(32'h0);
      ctlw(32'($random(seed)) | 32'h80000000);
      mkf({28'h0, 4'($random(seed))} % 9);
      send();
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `RFC_CTL_OFS, 32'h0, 1'b0);
    chk(rdat, 32'h0);
    results();
  end
endmodule
